// *** logic/dcbmfp_pkg.sv ***
// constants and types shared by both ends of the bus-matching fifo link
// assumes a single 40 MHz system clock drives both ends
package dcbmfp_pkg;
    localparam int DATA_W = 36;
    localparam int BYTE_W = 9;
    localparam int HALF_W = 18;
    localparam int ADDR_W = 10;
    localparam int PTR_W = 11;
    localparam logic [PTR_W-1:0] DEPTH_CNT = 11'h400;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam int SYS_CLK_MHZ = 40;
    // half period of the port clocks made by the controller, in ns
    localparam int PORT_HALF_NS = 200;
    localparam int PORT_HALF_CYC = (PORT_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int MRS_EDGES = 4;
    typedef enum logic [1:0] {
        DCBMFP_LONG,
        DCBMFP_WORD,
        DCBMFP_BYTE
    } dcbmfp_width_e;
endpackage

// *** logic/dcbmfp_if.sv ***
// pin-level link between the fifo device and its controlling master
// assumes the testbench instantiates it and joins both ends
`timescale 1ns/1ps
interface dcbmfp_if;
    import dcbmfp_pkg::*;
    logic write_side_clock;
    logic write_side_select_n;
    logic write_side_enable;
    logic [DATA_W-1:0] write_port_data;
    logic write_port_data_oe;
    logic read_side_clock;
    logic read_side_select_n;
    logic read_side_enable;
    logic [DATA_W-1:0] read_port_data;
    logic read_port_data_oe;
    logic empty_or_out_ready;
    logic full_or_in_ready;
    logic almost_empty_n;
    logic almost_full_n;
    logic master_reset_n;
    logic endian_or_timing_select;
    logic width_match_select;
    logic byte_size_select;

    modport dev_mp (
        input write_side_clock, write_side_select_n, write_side_enable,
        input write_port_data, read_side_clock, read_side_select_n,
        input read_side_enable, master_reset_n, endian_or_timing_select,
        input width_match_select, byte_size_select,
        output write_port_data_oe, read_port_data, read_port_data_oe,
        output empty_or_out_ready, full_or_in_ready, almost_empty_n,
        output almost_full_n
    );
    modport ctl_mp (
        output write_side_clock, write_side_select_n, write_side_enable,
        output write_port_data, read_side_clock, read_side_select_n,
        output read_side_enable, master_reset_n, endian_or_timing_select,
        output width_match_select, byte_size_select,
        input write_port_data_oe, read_port_data, read_port_data_oe,
        input empty_or_out_ready, full_or_in_ready, almost_empty_n,
        input almost_full_n
    );
endinterface

// *** logic/dcbmfp_sync.sv ***
// two-flop synchroniser bank with rising-edge detect per bit
// assumes inputs are foreign to sys_clk; first stage feeds only the second
`timescale 1ns/1ps
module dcbmfp_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (clk_en) begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign q = s2_ff;
    assign rise = s2_ff & ~s3_ff;
endmodule

// *** logic/dcbmfp_dev.sv ***
// fifo device end: 1k x 36 store, port a write side, port b read side
// assumes port clocks and controls arrive as pins sampled on sys_clk
// Summary of operation
// [RULE1] almost-empty low when count at or below offset
// [RULE2] almost-full low when free at or below offset
// [RULE3] select high in reset: most significant first
// [RULE4] select low in reset: least significant first
// [RULE5] after reset select high standard, low fall-through
// [RULE6] controller keeps timing select static afterwards
// [RULE7] width match low long, high byte/word
// [RULE8] controller keeps width match select static
// [RULE9] port a transfers and flags on port a edges
// [RULE10] port b transfers and flags on port b edges
// [RULE11] port a edge acts only with select low
// [RULE12] port a drivers off while select high
// [RULE13] port b edge acts only with select low; fall-through refill of a free output ignores select
// [RULE14] port b drivers off while select high
// [RULE15] standard mode: combined output shows empty
// [RULE16] fall-through: combined output shows output ready
// [RULE17] both data ports are 36 bits wide
// [RULE18] full in standard, input ready in fall-through
// [RULE19] port a edge acts only with enable high
// [RULE20] master reset spans four edges per port clock
// [RULE21] almost flags assert exactly at threshold
// [RULE22] pointers cross between port domains safely
//
`timescale 1ns/1ps
module dcbmfp_dev
    import dcbmfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    dcbmfp_if.dev_mp link,
    input wire logic [PTR_W-1:0] almost_empty_offset,
    input wire logic [PTR_W-1:0] almost_full_offset,
    output logic [PTR_W-1:0] fill_count
);
    logic [DATA_W-1:0] mem [0:1023];
    logic [PTR_W-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [PTR_W-1:0] wr_seen_b_ff, rd_seen_a_ff;
    logic [1:0] sub_ff;
    logic [DATA_W-1:0] data_ff;
    logic out_valid_ff, empty_n_ff, full_n_ff, ae_n_ff, af_n_ff;
    logic big_ff, fall_through_mode_ff;

    logic [DATA_W+2:0] a_q, a_rise;
    logic [1:0] b_q, b_rise;
    logic [4:0] st_q;
    logic a_edge, b_edge, mrs_n, cs_a_n, en_a, cs_b_n, en_b;
    logic [DATA_W-1:0] a_data;

    dcbmfp_sync #(.W(DATA_W + 3)) u_sync_a (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din({link.write_side_clock, link.write_side_select_n,
              link.write_side_enable, link.write_port_data}),
        .q(a_q),
        .rise(a_rise)
    );
    dcbmfp_sync #(.W(2)) u_sync_b (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din({link.read_side_clock, link.read_side_select_n}),
        .q(b_q),
        .rise(b_rise)
    );
    dcbmfp_sync #(.W(5)) u_sync_st (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din({link.master_reset_n, link.endian_or_timing_select,
              link.width_match_select, link.byte_size_select,
              link.read_side_enable}),
        .q(st_q),
        .rise()
    );

    assign a_edge = a_rise[DATA_W+2] & clk_en;
    assign cs_a_n = a_q[DATA_W+1];
    assign en_a = a_q[DATA_W];
    assign a_data = a_q[DATA_W-1:0];
    assign b_edge = b_rise[1] & clk_en;
    assign cs_b_n = b_q[0];
    assign en_b = st_q[0];
    assign mrs_n = st_q[4];

    dcbmfp_width_e width;
    always_comb begin
        if (!st_q[2]) begin
            width = DCBMFP_LONG; // RULE7
        end else if (st_q[1]) begin
            width = DCBMFP_BYTE;
        end else begin
            width = DCBMFP_WORD;
        end
    end

    function automatic logic [DATA_W-1:0] piece(
        input logic [DATA_W-1:0] w,
        input logic [1:0] k,
        input dcbmfp_width_e m,
        input logic big
    );
        logic [1:0] idx;
        idx = big ? 2'h3 - k : k;
        unique case (m)
            DCBMFP_BYTE: piece = {27'h0, w[idx*BYTE_W +: BYTE_W]};
            DCBMFP_WORD: piece = {18'h0, w[idx[0]*HALF_W +: HALF_W]};
            DCBMFP_LONG: piece = w;
        endcase
    endfunction

    // write side, port a edge domain
    logic [PTR_W-1:0] cnt_a, nxt_wr_ptr, nxt_cnt_a;
    logic wr_take;
    assign cnt_a = wr_ptr_ff - rd_seen_a_ff;
    assign wr_take = a_edge && !cs_a_n && en_a && cnt_a != DEPTH_CNT; // RULE11 RULE19
    assign nxt_wr_ptr = wr_take ? wr_ptr_ff + 11'h1 : wr_ptr_ff;
    assign nxt_cnt_a = nxt_wr_ptr - rd_ptr_ff;

    always_ff @(posedge sys_clk) begin
        if (wr_take) begin
            mem[wr_ptr_ff[ADDR_W-1:0]] <= a_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || (clk_en && !mrs_n)) begin
            wr_ptr_ff <= '0;
            rd_seen_a_ff <= '0;
            full_n_ff <= 1'b0;
            af_n_ff <= 1'b0;
        end else if (a_edge) begin // RULE9
            wr_ptr_ff <= nxt_wr_ptr;
            rd_seen_a_ff <= rd_ptr_ff; // RULE22
            full_n_ff <= nxt_cnt_a != DEPTH_CNT; // RULE18
            af_n_ff <= !((DEPTH_CNT - nxt_cnt_a) <= almost_full_offset); // RULE2 RULE21
        end
    end

    // read side, port b edge domain
    logic [PTR_W-1:0] cnt_b, nxt_rd_ptr, nxt_cnt_b;
    logic [1:0] last_sub, nxt_sub;
    logic rd_take, head_ok, load, nxt_valid;
    logic [DATA_W-1:0] nxt_data;
    assign cnt_b = wr_seen_b_ff - rd_ptr_ff;
    assign head_ok = cnt_b != '0;
    assign rd_take = b_edge && !cs_b_n && en_b; // RULE13
    assign last_sub = width == DCBMFP_BYTE ? 2'h3 :
                      width == DCBMFP_WORD ? 2'h1 : 2'h0;
    // fall-through refills the output as soon as it is free
    assign load = head_ok && (fall_through_mode_ff ? (!out_valid_ff || rd_take)
                                      : rd_take); // RULE15 RULE16

    always_comb begin
        nxt_rd_ptr = rd_ptr_ff;
        nxt_sub = sub_ff;
        nxt_data = data_ff;
        nxt_valid = out_valid_ff;
        if (load) begin
            nxt_data = piece(mem[rd_ptr_ff[ADDR_W-1:0]], sub_ff, width,
                             big_ff); // RULE3 RULE4
            nxt_valid = 1'b1;
            if (sub_ff == last_sub) begin
                nxt_sub = 2'h0;
                nxt_rd_ptr = rd_ptr_ff + 11'h1;
            end else begin
                nxt_sub = sub_ff + 2'h1;
            end
        end else if (rd_take) begin
            nxt_valid = 1'b0;
        end
    end
    assign nxt_cnt_b = wr_ptr_ff - nxt_rd_ptr;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || (clk_en && !mrs_n)) begin
            rd_ptr_ff <= '0;
            wr_seen_b_ff <= '0;
            sub_ff <= 2'h0;
            data_ff <= DATA_RST;
            out_valid_ff <= 1'b0;
            empty_n_ff <= 1'b0;
            ae_n_ff <= 1'b0;
        end else if (b_edge) begin // RULE10
            rd_ptr_ff <= nxt_rd_ptr;
            wr_seen_b_ff <= wr_ptr_ff; // RULE22
            sub_ff <= nxt_sub;
            data_ff <= nxt_data;
            out_valid_ff <= fall_through_mode_ff ? nxt_valid : 1'b0;
            empty_n_ff <= nxt_cnt_b != '0;
            ae_n_ff <= !(nxt_cnt_b <= almost_empty_offset); // RULE1 RULE21
        end
    end

    // endian caught while reset held, timing mode taken after it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            big_ff <= 1'b0;
            fall_through_mode_ff <= 1'b0;
        end else if (clk_en) begin
            if (!mrs_n) begin
                big_ff <= st_q[3]; // RULE3 RULE4
            end else begin
                fall_through_mode_ff <= !st_q[3]; // RULE5
            end
        end
    end

    // no port a read path exists, so its drivers stay off
    assign link.write_port_data_oe = 1'b0; // RULE12
    assign link.read_port_data = data_ff; // RULE17
    assign link.read_port_data_oe = !cs_b_n; // RULE14
    assign link.empty_or_out_ready = fall_through_mode_ff ? out_valid_ff : empty_n_ff;
    assign link.full_or_in_ready = full_n_ff;
    assign link.almost_empty_n = ae_n_ff;
    assign link.almost_full_n = af_n_ff;
    assign fill_count = cnt_a;
endmodule

// *** logic/dcbmfp_ctl.sv ***
// controller end: makes both port clocks, runs master reset, moves data
// assumes device outputs are foreign and sampled through dcbmfp_sync
`timescale 1ns/1ps
module dcbmfp_ctl
    import dcbmfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    dcbmfp_if.ctl_mp link,
    input wire logic cfg_big_endian,
    input wire logic cfg_fall_through,
    input wire logic cfg_width_match,
    input wire logic cfg_byte_size,
    input wire logic wr_valid,
    input wire logic [DATA_W-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_req,
    output logic rd_busy,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic run
);
    typedef enum logic {CTL_RESET, CTL_RUN} dcbmfp_ctl_e;
    dcbmfp_ctl_e state_ff;
    logic [4:0] half_cnt_ff;
    logic pclk_ff, mrs_n_ff, sel_ff;
    logic [2:0] mrs_cnt_ff;
    logic ena_ff, enb_ff, wr_pend_ff, rd_pend_ff, cap_ff, rd_valid_ff;
    logic [DATA_W-1:0] wr_hold_ff, wdata_ff, rd_data_ff;
    logic [DATA_W+1:0] in_q;
    logic tick, go_hi, go_lo, in_ready, out_ready;

    dcbmfp_sync #(.W(DATA_W + 2)) u_sync_in (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din({link.full_or_in_ready, link.empty_or_out_ready,
              link.read_port_data}),
        .q(in_q),
        .rise()
    );
    assign in_ready = in_q[DATA_W+1];
    assign out_ready = in_q[DATA_W];

    assign tick = clk_en && half_cnt_ff == 5'(PORT_HALF_CYC - 1);
    assign go_hi = tick && !pclk_ff;
    assign go_lo = tick && pclk_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            half_cnt_ff <= 5'h0;
            pclk_ff <= 1'b0;
        end else if (clk_en) begin
            half_cnt_ff <= tick ? 5'h0 : half_cnt_ff + 5'h1;
            pclk_ff <= tick ? !pclk_ff : pclk_ff;
        end
    end

    // hold master reset over more than the required port edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= CTL_RESET;
            mrs_n_ff <= 1'b0;
            mrs_cnt_ff <= 3'h0;
            sel_ff <= 1'b0;
        end else if (clk_en) begin
            unique case (state_ff)
                CTL_RESET: begin
                    sel_ff <= cfg_big_endian;
                    if (go_hi) begin
                        mrs_cnt_ff <= mrs_cnt_ff + 3'h1;
                    end
                    if (go_lo && mrs_cnt_ff > 3'(MRS_EDGES)) begin // RULE20
                        mrs_n_ff <= 1'b1;
                        sel_ff <= !cfg_fall_through;
                        state_ff <= CTL_RUN;
                    end
                end
                CTL_RUN: begin
                    sel_ff <= !cfg_fall_through; // RULE6
                end
            endcase
        end
    end

    // controls change on the falling half so they settle before rising
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_pend_ff <= 1'b0;
            wr_hold_ff <= DATA_RST;
            ena_ff <= 1'b0;
            wdata_ff <= DATA_RST;
        end else if (clk_en) begin
            if (wr_valid && !wr_pend_ff && state_ff == CTL_RUN) begin
                wr_pend_ff <= 1'b1;
                wr_hold_ff <= wr_data;
            end
            if (go_lo) begin
                ena_ff <= wr_pend_ff && in_ready; // RULE11 RULE19
                if (wr_pend_ff && in_ready) begin
                    wdata_ff <= wr_hold_ff;
                    wr_pend_ff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_pend_ff <= 1'b0;
            enb_ff <= 1'b0;
            cap_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= DATA_RST;
        end else if (clk_en) begin
            rd_valid_ff <= 1'b0;
            if (rd_req && !rd_pend_ff && state_ff == CTL_RUN) begin
                rd_pend_ff <= 1'b1;
            end
            if (go_lo) begin
                enb_ff <= rd_pend_ff && out_ready; // RULE13
                if (rd_pend_ff && out_ready) begin
                    rd_pend_ff <= 1'b0;
                end
                if (cap_ff) begin
                    rd_data_ff <= in_q[DATA_W-1:0];
                    rd_valid_ff <= 1'b1;
                    cap_ff <= 1'b0;
                end
            end
            // fall-through shows the word before the read edge
            if (go_hi && enb_ff) begin
                if (cfg_fall_through) begin
                    rd_data_ff <= in_q[DATA_W-1:0];
                    rd_valid_ff <= 1'b1;
                end else begin
                    cap_ff <= 1'b1;
                end
            end
        end
    end

    assign link.write_side_clock = pclk_ff;
    assign link.read_side_clock = pclk_ff;
    assign link.write_side_select_n = !ena_ff;
    assign link.write_side_enable = ena_ff;
    assign link.write_port_data = wdata_ff;
    assign link.read_side_select_n = state_ff != CTL_RUN;
    assign link.read_side_enable = enb_ff;
    assign link.master_reset_n = mrs_n_ff;
    assign link.endian_or_timing_select = sel_ff;
    assign link.width_match_select = cfg_width_match; // RULE8
    assign link.byte_size_select = cfg_byte_size;
    assign wr_ready = !wr_pend_ff && state_ff == CTL_RUN;
    assign rd_busy = rd_pend_ff || enb_ff || cap_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign run = state_ff == CTL_RUN;
endmodule

// *** verif/dcbmfp_checker.sv ***
// assertions on the fifo link signals, all in the sys_clk domain
// assumes it sits beside the interface instance in the bench top
`timescale 1ns/1ps
module dcbmfp_checker
    import dcbmfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic write_side_clock,
    input wire logic write_side_select_n,
    input wire logic write_side_enable,
    input wire logic write_port_data_oe,
    input wire logic read_side_clock,
    input wire logic read_side_select_n,
    input wire logic [DATA_W-1:0] read_port_data,
    input wire logic read_port_data_oe,
    input wire logic empty_or_out_ready,
    input wire logic full_or_in_ready,
    input wire logic master_reset_n,
    input wire logic endian_or_timing_select,
    input wire logic width_match_select
);
    logic clk_a_ff;
    logic clk_b_ff;
    logic [4:0] rise_a_ff;
    logic [4:0] rise_b_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // device resyncs the port clocks, so outputs trail a rise a little
    always_ff @(posedge sys_clk) begin
        clk_a_ff <= write_side_clock;
        clk_b_ff <= read_side_clock;
        rise_a_ff <= {rise_a_ff[3:0], write_side_clock & ~clk_a_ff};
        rise_b_ff <= {rise_b_ff[3:0], read_side_clock & ~clk_b_ff};
    end

    // master reset entry clears outputs off-edge, so look only after it
    sequence s_running;
        master_reset_n [*4];
    endsequence

    a_porta_oe_off: assert property (
        write_side_select_n |-> !write_port_data_oe)
        else $error("port a data driven while deselected");
    a_portb_oe_off: assert property (
        read_side_select_n [*3] |-> !read_port_data_oe)
        else $error("port b data driven while deselected");
    a_full_on_edge: assert property (
        s_running ##0 $changed(full_or_in_ready) |-> (|rise_a_ff))
        else $error("input flag moved away from a port a rise");
    a_empty_on_edge: assert property (
        s_running ##0 $changed(empty_or_out_ready) |-> (|rise_b_ff))
        else $error("output flag moved away from a port b rise");
    a_data_on_edge: assert property (
        s_running ##0 $changed(read_port_data)
        |-> (|rise_b_ff) && !$past(read_side_select_n, 3))
        else $error("port b data moved without a selected rise");
    a_write_gated: assert property (
        s_running ##0 $fell(full_or_in_ready)
        |-> $past(write_side_enable, 3) && !$past(write_side_select_n, 3))
        else $error("fifo filled without an enabled write");
    a_timing_static: assert property (
        s_running |-> $stable(endian_or_timing_select))
        else $error("timing select moved during operation");
    a_width_static: assert property (
        s_running |-> $stable(width_match_select))
        else $error("width match select moved during operation");
endmodule

// *** verif/dcbmfp_tb_top.sv ***
// self-checking bench: controller and fifo device joined by the link
// assumes one 40 MHz sys_clk; the controller makes both port clocks
`timescale 1ns/1ps
module dcbmfp_tb_top
    import dcbmfp_pkg::*;
;
    typedef struct {
        logic big;
        logic ft;
        logic wm;
        logic bs;
        int n;
        logic [DATA_W-1:0] e [4];
    } dcbmfp_row_s;
    localparam logic [DATA_W-1:0] WORD = 36'h123456789;
    // fill and drain of 1024 words dominate the run time
    localparam int LIMIT = 90000;
    dcbmfp_row_s rows [6] = '{
        '{1'b1, 1'b0, 1'b0, 1'b0, 1, '{WORD, 36'h0, 36'h0, 36'h0}},
        '{1'b0, 1'b1, 1'b0, 1'b0, 1, '{WORD, 36'h0, 36'h0, 36'h0}},
        '{1'b1, 1'b0, 1'b1, 1'b0, 2, '{36'h048d1, 36'h16789, 36'h0, 36'h0}},
        '{1'b0, 1'b1, 1'b1, 1'b0, 2, '{36'h16789, 36'h048d1, 36'h0, 36'h0}},
        '{1'b1, 1'b1, 1'b1, 1'b1, 4, '{36'h024, 36'h0d1, 36'h0b3, 36'h189}},
        '{1'b0, 1'b0, 1'b1, 1'b1, 4, '{36'h189, 36'h0b3, 36'h0d1, 36'h024}}
    };
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic cfg_big_endian = 1'b0;
    logic cfg_fall_through = 1'b0;
    logic cfg_width_match = 1'b0;
    logic cfg_byte_size = 1'b0;
    logic wr_valid = 1'b0;
    logic [DATA_W-1:0] wr_data = 36'h0;
    logic rd_req = 1'b0;
    logic [PTR_W-1:0] ae_off = 11'h3;
    logic [PTR_W-1:0] af_off = 11'h4;
    logic wr_ready;
    logic rd_busy;
    logic rd_valid;
    logic run;
    logic [DATA_W-1:0] rd_data;
    logic [PTR_W-1:0] fill_count;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    dcbmfp_if link_if ();
    dcbmfp_dev i_dcbmfp_dev (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .link(link_if), .almost_empty_offset(ae_off),
        .almost_full_offset(af_off), .fill_count(fill_count));
    dcbmfp_ctl i_dcbmfp_ctl (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .link(link_if), .cfg_big_endian(cfg_big_endian),
        .cfg_fall_through(cfg_fall_through),
        .cfg_width_match(cfg_width_match), .cfg_byte_size(cfg_byte_size),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
        .rd_req(rd_req), .rd_busy(rd_busy), .rd_data(rd_data),
        .rd_valid(rd_valid), .run(run));
    dcbmfp_checker i_dcbmfp_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .write_side_clock(link_if.write_side_clock),
        .write_side_select_n(link_if.write_side_select_n),
        .write_side_enable(link_if.write_side_enable),
        .write_port_data_oe(link_if.write_port_data_oe),
        .read_side_clock(link_if.read_side_clock),
        .read_side_select_n(link_if.read_side_select_n),
        .read_port_data(link_if.read_port_data),
        .read_port_data_oe(link_if.read_port_data_oe),
        .empty_or_out_ready(link_if.empty_or_out_ready),
        .full_or_in_ready(link_if.full_or_in_ready),
        .master_reset_n(link_if.master_reset_n),
        .endian_or_timing_select(link_if.endian_or_timing_select),
        .width_match_select(link_if.width_match_select));

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
            input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // config inputs only change under sys_rst, as the controller needs
    task automatic do_reset(input dcbmfp_row_s r);
        int k;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        cfg_big_endian <= r.big;
        cfg_fall_through <= r.ft;
        cfg_width_match <= r.wm;
        cfg_byte_size <= r.bs;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 400 && run !== 1'b1; k++) @(negedge sys_clk);
        check("run", run, 1'b1);
        repeat (40) @(negedge sys_clk);
    endtask

    task automatic put_word(input logic [DATA_W-1:0] w);
        int k;
        @(posedge sys_clk);
        wr_valid <= 1'b1;
        wr_data <= w;
        @(negedge sys_clk);
        for (k = 0; k < 200 && wr_ready !== 1'b1; k++) @(negedge sys_clk);
        @(posedge sys_clk);
        wr_valid <= 1'b0;
    endtask

    task automatic get_piece(output logic [DATA_W-1:0] d);
        int k;
        @(negedge sys_clk);
        for (k = 0; k < 200 && rd_busy !== 1'b0; k++) @(negedge sys_clk);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        @(negedge sys_clk);
        for (k = 0; k < 200 && rd_valid !== 1'b1; k++) @(negedge sys_clk);
        d = rd_data;
    endtask

    // pieces narrower than a long word sit in the low bits
    function automatic logic [DATA_W-1:0] piece_mask(input dcbmfp_row_s r);
        if (!r.wm) begin
            return {DATA_W{1'b1}};
        end
        return r.bs ? 36'h1ff : 36'h3ffff;
    endfunction

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            $display("timeout after %0d cycles", cycles);
            give_verdict();
        end
    end

    initial begin
        logic [DATA_W-1:0] d;
        int i;
        int j;
        for (i = 0; i < 6; i++) begin
            do_reset(rows[i]);
            check("flag empty", link_if.empty_or_out_ready, 1'b0);
            put_word(WORD);
            repeat (60) @(negedge sys_clk);
            check("flag ready", link_if.empty_or_out_ready, 1'b1);
            check("almost empty", link_if.almost_empty_n, 1'b0);
            check("space", link_if.full_or_in_ready, 1'b1);
            check("oe b", link_if.read_port_data_oe, 1'b1);
            for (j = 0; j < rows[i].n; j++) begin
                get_piece(d);
                check("piece", d & piece_mask(rows[i]), rows[i].e[j]);
            end
            repeat (60) @(negedge sys_clk);
            check("drained", link_if.empty_or_out_ready, 1'b0);
            $display("test row %0d done", i);
        end
        // fill to the brim, then drain, watching both almost flags
        do_reset(rows[0]);
        for (i = 0; i < 1024; i++) begin
            put_word(WORD ^ 36'(i));
            if (i >= 1018) begin
                for (j = 0; j < 100 && fill_count !== 11'(i + 1); j++)
                    @(negedge sys_clk);
                repeat (4) @(negedge sys_clk);
                check("almost full", link_if.almost_full_n, i < 1019);
                check("space", link_if.full_or_in_ready, i < 1023);
            end
        end
        for (i = 0; i < 1024; i++) begin
            get_piece(d);
            check("drain", d, WORD ^ 36'(i));
            if (i >= 1019 && i <= 1021) begin
                repeat (2) @(negedge sys_clk);
                check("almost empty", link_if.almost_empty_n, i < 1020);
            end
        end
        repeat (60) @(negedge sys_clk);
        check("empty", link_if.empty_or_out_ready, 1'b0);
        check("almost full off", link_if.almost_full_n, 1'b1);
        $display("test fill and drain done");
        // word taken by the controller, then everything frozen
        put_word(WORD);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (60) @(negedge sys_clk);
        check("frozen", link_if.empty_or_out_ready, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (60) @(negedge sys_clk);
        check("thawed", link_if.empty_or_out_ready, 1'b1);
        $display("test clock enable done");
        give_verdict();
    end
endmodule
